/* rtl/yrcc_top.v */
// Year and realtime counter control/status block with AXI4-Lite register access
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "yrcc_map.vh"
module yrcc_top #(
    parameter TIMEOUT_CYC = `YRCC_SLOW_TIMEOUT_CYC
) (
    input wire clk_sys,
    input wire reset,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire osc_clk_in,
    input wire gpio_clk_in,
    output reg osc_enable_q,
    output reg year_tick_q,
    output reg realtime_tick_q,
    output reg irq_q
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [7:0] aw_addr_q; // Captured write address
    reg aw_full_q; // Write address held
    reg [31:0] w_data_q; // Captured write data
    reg [3:0] w_strb_q; // Captured byte enables
    reg w_full_q; // Write data held
    reg [31:0] slow_reg_q [0:`YRCC_NUM_PEND-1]; // Slow-domain holding values
    reg [31:0] ctrl_q; // Writable control bits only
    reg [`YRCC_NUM_PEND-1:0] pend_q; // Write pending flags
    reg [`YRCC_IRQ_W-1:0] irq_stat_q; // Sticky event bits
    reg [`YRCC_IRQ_W-1:0] irq_mask_q; // One enables the event
    reg run_prev_q; // Running flag last cycle
    wire slow_edge;
    wire running;
    wire wr_go;
    wire [31:0] bmask;
    reg wr_hit;
    reg [3:0] wr_idx;
    reg wr_ctrl;
    reg wr_stat;
    reg wr_mask;
    reg rd_hit;
    reg [31:0] rd_val;
    wire [`YRCC_NUM_PEND-1:0] pend_clr;
    wire ydone;
    wire rdone;
    wire [31:0] stat_word;
    wire [1:0] tick_w;
    wire [1:0] skip_w;
    // ****************************************************************
    // Slow clock detection
    // ****************************************************************
    yrcc_slow_detect #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_detect (
        .clk_sys(clk_sys),
        .reset(reset),
        .osc_clk_in(osc_clk_in),
        .gpio_clk_in(gpio_clk_in),
        .bypass_sel(ctrl_q[`YRCC_B_BYPASS]),
        .slow_edge_q(slow_edge),
        .running_q(running)
    );
    // ****************************************************************
    // AXI4-Lite write channel capture
    // ****************************************************************
    assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    // Address and data are taken independently, in either order
    always @(posedge clk_sys) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `YRCC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_full_q & ~s_axi_awready;
            s_axi_wready <= ~w_full_q & ~s_axi_wready;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                // Response issued once both halves are in
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit | wr_ctrl | wr_stat | wr_mask) ?
                               `YRCC_RESP_OKAY : `YRCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ****************************************************************
    // Write address decode
    // ****************************************************************
    // Maps a slow-domain register offset onto its pending flag index
    always @* begin
        wr_hit = 1'b1;
        wr_idx = 4'h0;
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (aw_addr_q == `YRCC_OFF_YEAR_LOAD) begin
            wr_idx = `YRCC_PI_YLOAD;
        end else if (aw_addr_q == `YRCC_OFF_YEAR_MATCH0) begin
            wr_idx = `YRCC_PI_YM0;
        end else if (aw_addr_q == `YRCC_OFF_YEAR_MATCH1) begin
            wr_idx = `YRCC_PI_YM1;
        end else if (aw_addr_q == `YRCC_OFF_YEAR_MATCH2) begin
            wr_idx = `YRCC_PI_YM2;
        end else if (aw_addr_q == `YRCC_OFF_YEAR_TRIM) begin
            wr_idx = `YRCC_PI_YTRIM;
        end else if (aw_addr_q == `YRCC_OFF_RT_LOAD) begin
            wr_idx = `YRCC_PI_RLOAD;
        end else if (aw_addr_q == `YRCC_OFF_RT_MATCH0) begin
            wr_idx = `YRCC_PI_RM0;
        end else if (aw_addr_q == `YRCC_OFF_RT_MATCH1) begin
            wr_idx = `YRCC_PI_RM1;
        end else if (aw_addr_q == `YRCC_OFF_RT_MATCH2) begin
            wr_idx = `YRCC_PI_RM2;
        end else if (aw_addr_q == `YRCC_OFF_RT_TRIM) begin
            wr_idx = `YRCC_PI_RTRIM;
        end else if (aw_addr_q == `YRCC_OFF_CTRL) begin
            wr_hit = 1'b0;
            wr_ctrl = 1'b1;
        end else if (aw_addr_q == `YRCC_OFF_IRQ_STATUS) begin
            wr_hit = 1'b0;
            wr_stat = 1'b1;
        end else if (aw_addr_q == `YRCC_OFF_IRQ_MASK) begin
            wr_hit = 1'b0;
            wr_mask = 1'b1;
        end else begin
            // Unmapped: nothing stored, error response
            wr_hit = 1'b0;
        end
    end
    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Holding values and control: only the written byte lanes change; the mask ignores the strobes
    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= 32'h00000000;
            irq_mask_q <= {`YRCC_IRQ_W{1'b0}};
        end else if (wr_go) begin
            if (wr_hit) begin
                slow_reg_q[wr_idx] <= (slow_reg_q[wr_idx] & ~bmask) | (w_data_q & bmask);
            end
            if (wr_ctrl) begin
                // Status and reserved positions are not storable
                ctrl_q <= (ctrl_q & ~(bmask & `YRCC_CTRL_WMASK)) |
                          (w_data_q & bmask & `YRCC_CTRL_WMASK);
            end
            if (wr_mask) begin
                irq_mask_q <= w_data_q[`YRCC_IRQ_W-1:0];
            end
        end
    end
    // ****************************************************************
    // Write pending flags
    // ****************************************************************
    // Each flag waits two slow edges, the transfer time into the slow domain.
    // A repeat write while pending restarts the wait rather than being lost.
    genvar gi;
    generate
        for (gi = 0; gi < `YRCC_NUM_PEND; gi = gi + 1) begin : g_pend
            reg edge_seen_q; // First slow edge since the write
            wire set_now;
            assign set_now = wr_go & ((wr_hit & (wr_idx == gi)) |
                             (wr_ctrl & (gi == `YRCC_PI_CTRL)));
            assign pend_clr[gi] = pend_q[gi] & slow_edge & edge_seen_q & ~set_now;
            always @(posedge clk_sys) begin
                if (reset) begin
                    pend_q[gi] <= 1'b0;
                    edge_seen_q <= 1'b0;
                end else if (set_now) begin
                    pend_q[gi] <= 1'b1;
                    edge_seen_q <= 1'b0;
                end else if (pend_q[gi] & slow_edge) begin
                    edge_seen_q <= 1'b1;
                    if (edge_seen_q) begin
                        pend_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    // ****************************************************************
    // Counter tick generation with trim or trim skip
    // ****************************************************************
    // Side 0 is year, side 1 realtime; enable gates both
    assign skip_w = {ctrl_q[`YRCC_B_RSKIP], ctrl_q[`YRCC_B_YSKIP]};
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tick
            reg [`YRCC_TRIM_W-1:0] div_q; // Trim divider count
            reg tick_q;
            wire [`YRCC_TRIM_W-1:0] trim;
            assign trim = slow_reg_q[gi ? `YRCC_PI_RTRIM : `YRCC_PI_YTRIM][`YRCC_TRIM_W-1:0];
            assign tick_w[gi] = tick_q;
            always @(posedge clk_sys) begin
                if (reset) begin
                    div_q <= {`YRCC_TRIM_W{1'b0}};
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b0;
                    if (ctrl_q[`YRCC_B_ENABLE] & slow_edge) begin
                        if (skip_w[gi] | (div_q >= trim)) begin
                            div_q <= {`YRCC_TRIM_W{1'b0}};
                            tick_q <= 1'b1;
                        end else begin
                            div_q <= div_q + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate
    // ****************************************************************
    // Interrupt events and output registers
    // ****************************************************************
    assign ydone = |pend_clr[`YRCC_PI_YTRIM:`YRCC_PI_YLOAD];
    assign rdone = |pend_clr[`YRCC_PI_RTRIM:`YRCC_PI_RLOAD];
    // Hardware set wins over a same-cycle write-one clear
    always @(posedge clk_sys) begin
        if (reset) begin
            irq_stat_q <= {`YRCC_IRQ_W{1'b0}};
            run_prev_q <= 1'b0;
            irq_q <= 1'b0;
            osc_enable_q <= 1'b0;
            year_tick_q <= 1'b0;
            realtime_tick_q <= 1'b0;
        end else begin
            run_prev_q <= running;
            irq_stat_q <= (irq_stat_q & ~((wr_go & wr_stat) ?
                           w_data_q[`YRCC_IRQ_W-1:0] : {`YRCC_IRQ_W{1'b0}})) |
                          {running & ~run_prev_q, rdone, ydone};
            irq_q <= |(irq_stat_q & irq_mask_q);
            osc_enable_q <= ctrl_q[`YRCC_B_ENABLE];
            year_tick_q <= tick_w[0];
            realtime_tick_q <= tick_w[1];
        end
    end
    // ****************************************************************
    // Read channel
    // ****************************************************************
    // Status word assembly; reserved bits read zero
    assign stat_word = {11'h000,
        pend_q[`YRCC_PI_RTRIM:`YRCC_PI_RLOAD],
        1'b0, ctrl_q[`YRCC_B_BYPASS], 1'b0, ctrl_q[`YRCC_B_RSKIP],
        1'b0, ctrl_q[`YRCC_B_YSKIP], 1'b0, ctrl_q[`YRCC_B_ENABLE],
        pend_q[`YRCC_PI_CTRL], 1'b0, running,
        pend_q[`YRCC_PI_YTRIM:`YRCC_PI_YLOAD]};
    // Read address decode
    always @* begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        if (s_axi_araddr == `YRCC_OFF_CTRL) begin
            rd_val = stat_word;
        end else if (s_axi_araddr == `YRCC_OFF_IRQ_STATUS) begin
            rd_val = {29'h00000000, irq_stat_q};
        end else if (s_axi_araddr == `YRCC_OFF_IRQ_MASK) begin
            rd_val = {29'h00000000, irq_mask_q};
        end else if ((s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `YRCC_OFF_RT_MATCH2)) begin
            // Trim sits below load, so the trim offsets map out of order
            rd_val = slow_reg_q[(s_axi_araddr == `YRCC_OFF_YEAR_TRIM) ? `YRCC_PI_YTRIM :
                     (s_axi_araddr == `YRCC_OFF_RT_TRIM) ? `YRCC_PI_RTRIM : s_axi_araddr[5:2] - 4'h1];
        end else begin
            rd_hit = 1'b0;
        end
    end
    // One read at a time; data held until rready
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `YRCC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `YRCC_RESP_OKAY : `YRCC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // yrcc_top
`default_nettype wire

/* shared/yrcc_map.vh */
// Register map, field positions and timing constants of the year/realtime counter control
`ifndef YRCC_MAP_VH
`define YRCC_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define YRCC_OFF_YEAR_TRIM 8'h00
`define YRCC_OFF_YEAR_LOAD 8'h04
`define YRCC_OFF_YEAR_MATCH0 8'h08
`define YRCC_OFF_YEAR_MATCH1 8'h0c
`define YRCC_OFF_YEAR_MATCH2 8'h10
`define YRCC_OFF_CTRL 8'h14
`define YRCC_OFF_RT_TRIM 8'h18
`define YRCC_OFF_RT_LOAD 8'h1c
`define YRCC_OFF_RT_MATCH0 8'h20
`define YRCC_OFF_RT_MATCH1 8'h24
`define YRCC_OFF_RT_MATCH2 8'h28
`define YRCC_OFF_IRQ_STATUS 8'h30
`define YRCC_OFF_IRQ_MASK 8'h34
// ****************************************************************
// Pending flag indices
// ****************************************************************
`define YRCC_PI_YLOAD 4'd0
`define YRCC_PI_YM0 4'd1
`define YRCC_PI_YM1 4'd2
`define YRCC_PI_YM2 4'd3
`define YRCC_PI_YTRIM 4'd4
`define YRCC_PI_CTRL 4'd5
`define YRCC_PI_RLOAD 4'd6
`define YRCC_PI_RM0 4'd7
`define YRCC_PI_RM1 4'd8
`define YRCC_PI_RM2 4'd9
`define YRCC_PI_RTRIM 4'd10
`define YRCC_NUM_PEND 11
// ****************************************************************
// Control/status field positions
// ****************************************************************
`define YRCC_B_YLOAD_P 0
`define YRCC_B_YTRIM_P 4
`define YRCC_B_RUNNING 5
`define YRCC_B_CTRL_P 7
`define YRCC_B_ENABLE 8
`define YRCC_B_YSKIP 10
`define YRCC_B_RSKIP 12
`define YRCC_B_BYPASS 14
`define YRCC_B_RLOAD_P 16
`define YRCC_B_RTRIM_P 20
`define YRCC_CTRL_WMASK 32'h00005500
// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define YRCC_IRQ_W 3
`define YRCC_IRQ_YDONE 0
`define YRCC_IRQ_RDONE 1
`define YRCC_IRQ_RUNUP 2
// ****************************************************************
// Misc constants
// ****************************************************************
`define YRCC_RESP_OKAY 2'b00
`define YRCC_RESP_SLVERR 2'b10
`define YRCC_TRIM_W 16
`define YRCC_RUN_EDGES 2'd2
// Stopped after two periods with no edge
`define YRCC_SLOW_TIMEOUT_NS 61035
`define YRCC_CLK_PERIOD_NS 10
`define YRCC_SLOW_TIMEOUT_CYC (`YRCC_SLOW_TIMEOUT_NS / `YRCC_CLK_PERIOD_NS)
`endif

/* rtl/yrcc_slow_detect.v */
// Slow clock source select, synchroniser, edge detector and running detector
`timescale 1ns/10ps
`default_nettype none
`include "yrcc_map.vh"
module yrcc_slow_detect #(
    parameter TIMEOUT_CYC = `YRCC_SLOW_TIMEOUT_CYC
) (
    input wire clk_sys,
    input wire reset,
    input wire osc_clk_in,
    input wire gpio_clk_in,
    input wire bypass_sel,
    output reg slow_edge_q,
    output reg running_q
);
    // ****************************************************************
    // Two-stage synchronisers for both candidate sources
    // ****************************************************************
    reg osc_s1_q;
    reg osc_s2_q;
    reg gpio_s1_q;
    reg gpio_s2_q;
    reg sel_prev_q; // Previous selected synchronised level
    reg [15:0] idle_cnt_q; // Cycles since last rising edge
    reg [1:0] edge_cnt_q; // Consecutive edges seen, saturating
    wire sel_lvl;
    wire rise;
    // Stage one is read only by stage two
    always @(posedge clk_sys) begin
        if (reset) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            gpio_s1_q <= 1'b0;
            gpio_s2_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            gpio_s1_q <= gpio_clk_in;
            gpio_s2_q <= gpio_s1_q;
        end
    end
    // Bypass chooses the pin source as a test mode
    assign sel_lvl = bypass_sel ? gpio_s2_q : osc_s2_q;
    assign rise = sel_lvl & ~sel_prev_q;
    // ****************************************************************
    // Edge and running detection
    // ****************************************************************
    // Running needs two edges, the second arriving before the timeout
    always @(posedge clk_sys) begin
        if (reset) begin
            sel_prev_q <= 1'b0;
            idle_cnt_q <= 16'h0000;
            edge_cnt_q <= 2'b00;
            slow_edge_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_lvl;
            slow_edge_q <= rise;
            if (rise) begin
                idle_cnt_q <= 16'h0000;
                if (edge_cnt_q != `YRCC_RUN_EDGES) begin
                    edge_cnt_q <= edge_cnt_q + 2'b01;
                end
            end else if (idle_cnt_q >= TIMEOUT_CYC[15:0]) begin
                // Clock stopped: restart the two-edge qualification
                edge_cnt_q <= 2'b00;
            end else begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
            end
            running_q <= (edge_cnt_q == `YRCC_RUN_EDGES) &&
                         (idle_cnt_q < TIMEOUT_CYC[15:0]);
        end
    end
endmodule // yrcc_slow_detect
`default_nettype wire

/* tb/yrcc_checker.sv */
// Port-level checks of the counter control block
`timescale 1ns/10ps
`default_nettype none
`include "yrcc_map.vh"
module yrcc_checker (
    input wire clk_sys,
    input wire reset,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire osc_enable_q,
    input wire year_tick_q,
    input wire realtime_tick_q
);
    // ****************************************************************
    // Read tracking and properties
    // ****************************************************************
    // Offset of the read in flight
    logic [7:0] rd_addr_q;
    always_ff @(posedge clk_sys) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    // Read answer from the control register
    wire ctrl_rd = s_axi_rvalid && (rd_addr_q == `YRCC_OFF_CTRL);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Both halves taken together: held one cycle, answer the next
    property p_bfollow; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_bfollow: assert property (p_bfollow) else $error("write answer missing");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_resv; ctrl_rd |-> (s_axi_rdata & 32'hffe0aa40) == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("control reserved bit set");
    property p_enrd; ctrl_rd |-> s_axi_rdata[`YRCC_B_ENABLE] == osc_enable_q; endproperty
    a_enrd: assert property (p_enrd) else $error("enable bit and output differ");
    property p_off; (!osc_enable_q) [*3] |-> !year_tick_q && !realtime_tick_q; endproperty
    a_off: assert property (p_off) else $error("tick while disabled");
    property p_ypulse; year_tick_q |=> !year_tick_q; endproperty
    a_ypulse: assert property (p_ypulse) else $error("year tick too long");
    property p_rpulse; realtime_tick_q |=> !realtime_tick_q; endproperty
    a_rpulse: assert property (p_rpulse) else $error("realtime tick too long");
endmodule // yrcc_checker
bind yrcc_top yrcc_checker u_chk (.*);
`default_nettype wire

/* tb/yrcc_slow_src.sv */
// Behavioural slow clock source: crystal, overdriven input or pin drive
`timescale 1ns/10ps
`default_nettype none
module yrcc_slow_src #(
    parameter real HALF_NS = 400.0
) (
    input wire logic run,
    output logic clk_o
);
    // 3 ns off the clock grid; a stopped source stands low
    initial begin
        clk_o = 1'b0;
        #3;
        forever #(HALF_NS) clk_o = run ? ~clk_o : 1'b0;
    end
endmodule // yrcc_slow_src
`default_nettype wire

/* tb/year_rtc_counter_control_tb.sv */
// Self-checking bench of the counter control block
`timescale 1ns/10ps
`default_nettype none
`include "yrcc_map.vh"
module year_rtc_counter_control_tb;
    // ****************************************************************
    // Signals, design and slow sources
    // ****************************************************************
    localparam logic [31:0] PEND = 32'h001f009f; // All write-pending flags
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run_osc = 1'b0, run_gpio = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic osc_clk_in, gpio_clk_in, osc_enable_q, year_tick_q, realtime_tick_q, irq_q;
    int failures = 0, check_count = 0, cyc = 0;
    // Register cases: offset, write data, read mask, expected read, expected response
    logic [7:0] ra [5] = '{8'h14, 8'h14, 8'h34, 8'h2c, 8'h3c};
    logic [31:0] rw [5] = '{32'hffffaaff, 32'h1400, 32'h7, 32'h1, 32'h1};
    logic [31:0] rm [5] = '{32'h5500, 32'h5500, 32'h7, 32'hffffffff, 32'hffffffff};
    logic [31:0] rx [5] = '{32'h0, 32'h1400, 32'h7, 32'h0, 32'h0};
    logic [1:0] rr [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    // Slow-domain registers and the flag each one raises
    logic [7:0] po [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
    int pb [10] = '{4, 0, 1, 2, 3, 20, 16, 17, 18, 19};
    always #5 clk_sys = ~clk_sys;
    yrcc_top #(.TIMEOUT_CYC(200)) DUT (
        .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .osc_clk_in(osc_clk_in), .gpio_clk_in(gpio_clk_in),
        .osc_enable_q(osc_enable_q), .year_tick_q(year_tick_q),
        .realtime_tick_q(realtime_tick_q), .irq_q(irq_q)
    );
    // Periods of 80 and 40 cycles
    yrcc_slow_src #(.HALF_NS(400.0)) u_osc (.run(run_osc), .clk_o(osc_clk_in));
    yrcc_slow_src #(.HALF_NS(200.0)) u_gpio (.run(run_gpio), .clk_o(gpio_clk_in));
    // ****************************************************************
    // Bus cycles, comparisons and closing
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw = 1'b1, w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge clk_sys);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        // Late bready: answer must stand
        s_axi_bready <= 1'b1;
        @(posedge clk_sys);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clk_sys);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Poll the control register until the masked field settles, bounded
    task automatic wait_bits(input logic [31:0] m, input logic [31:0] e);
        int n = 0;
        do begin
            rd(`YRCC_OFF_CTRL, d, r);
            n++;
        end while ((d & m) !== e && n < 100);
        chk("ctrl poll", e, d & m);
    endtask
    // Write one slow register, see only its flag raised, then wait for it to drop
    task automatic wrp(input logic [7:0] a, input logic [31:0] v, input int b);
        wr(a, v, r);
        rd(`YRCC_OFF_CTRL, d, r);
        chk("pending", 32'h1 << b, d & PEND);
        wait_bits(PEND, 32'h0);
        if (a != `YRCC_OFF_CTRL) begin
            rd(a, d, r);
            chk("readback", v, d);
        end
    endtask
    // Cycles between two consecutive ticks of one counter
    task automatic gap(input logic yr, input int e);
        int c = 0;
        do @(posedge clk_sys); while (!(yr ? year_tick_q : realtime_tick_q));
        do begin
            @(posedge clk_sys);
            c++;
        end while (!(yr ? year_tick_q : realtime_tick_q));
        chk("tick gap", e, c);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(`YRCC_OFF_CTRL, d, r);
        chk("ctrl reset", 32'h0, d & ~32'h20);
        run_osc <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wait_bits(PEND, 32'h0);
            wr(ra[i], rw[i], r);
            chk("bresp", rr[i], r);
            rd(ra[i], d, r);
            chk("rresp", rr[i], r);
            chk("rdata", rx[i], d & rm[i]);
        end
        for (int i = 0; i < 10; i++) wrp(po[i], 32'h0, pb[i]);
        wait_bits(32'h20, 32'h20);
        chk("irq up", 32'h1, irq_q);
        wr(`YRCC_OFF_IRQ_MASK, 32'h0, r);
        wr(`YRCC_OFF_IRQ_STATUS, 32'h7, r);
        chk("irq masked", 32'h0, irq_q);
        wrp(`YRCC_OFF_YEAR_LOAD, 32'h5, 0);
        rd(`YRCC_OFF_IRQ_STATUS, d, r);
        chk("year done", 32'h1, d & 32'h1);
        wr(`YRCC_OFF_IRQ_MASK, 32'h1, r);
        chk("irq unmasked", 32'h1, irq_q);
        wr(`YRCC_OFF_IRQ_STATUS, 32'h1, r);
        chk("irq cleared", 32'h0, irq_q);
        wrp(`YRCC_OFF_YEAR_TRIM, 32'h3, 4);
        wrp(`YRCC_OFF_RT_TRIM, 32'h1, 20);
        wrp(`YRCC_OFF_CTRL, 32'h500, 7);
        gap(1'b1, 80);
        gap(1'b0, 160);
        wrp(`YRCC_OFF_CTRL, 32'h1100, 7);
        gap(1'b1, 320);
        gap(1'b0, 80);
        run_osc <= 1'b0;
        wait_bits(32'h20, 32'h0);
        run_gpio <= 1'b1;
        wrp(`YRCC_OFF_CTRL, 32'h5500, 7);
        wait_bits(32'h20, 32'h20);
        gap(1'b1, 40);
        finish_test();
    end
endmodule // year_rtc_counter_control_tb
`default_nettype wire
